// File: hdl/tacs_map.vh
// Overview of operation
// - Status bits 11:8 show write location
// - Status bits 7:4 show read location
// - Status bit 3 high when FIFO full
// - Status bit 2 high when FIFO empty
// - Result into full FIFO sets overrun, dropped
// - Overrun flag raises overrun interrupt request
// - Status bit 0 high when count reaches watermark
// - Bank of 32 sixteen-bit step words
// - Low-word bits 15:14 read zero
// - High word: settle, in+, in-, ref+ fields
// - Low word: bias switches and ref- fields
// - Each bank entry written individually from bus
// - Idle waits settle cycles before pen interrupt
// - Idle routes positive input and negative input
// - Idle positive reference from bits 1:0
// - Idle negative reference from bits 1:0
// - Masked view shows five interrupts, bits 4:0
// - Clear write ones clear latched interrupts
// - Clear pulse lasts exactly one clock
// - Bit 2 clears brown-out, bit 1 pen
// - Bit 0 clears end-of-sequence interrupt
// - FIFO holds 16; overrun clears on read
// - Watermark clears once read below level
`ifndef TACS_MAP_VH
`define TACS_MAP_VH
// ==================================================
// Register offsets
`define TACS_FILL_VIEW_ADDR 8'h20
`define TACS_BANK_BASE_ADDR 8'h24
`define TACS_IDLE_HIGH_ADDR 8'hA4
`define TACS_IDLE_LOW_ADDR 8'hA8
`define TACS_MASKED_ADDR 8'hAC
`define TACS_CLEAR_ADDR 8'hB0
// ==================================================
// Fields
`define TACS_FS_WR_HI 11
`define TACS_FS_WR_LO 8
`define TACS_FS_RD_HI 7
`define TACS_FS_RD_LO 4
`define TACS_FS_FULL 3
`define TACS_FS_EMPTY 2
`define TACS_FS_OVR 1
`define TACS_FS_WMK 0
`define TACS_SETTLE_HI 15
`define TACS_SETTLE_LO 7
`define TACS_INP_HI 6
`define TACS_INP_LO 3
`define TACS_INM 2
`define TACS_REF_HI 1
`define TACS_REF_LO 0
`define TACS_BIAS_HI 13
`define TACS_BIAS_LO 2
`define TACS_LOW_MASK 16'h3FFF
`define TACS_IRQ_BO 2
`define TACS_IRQ_PEN 1
`define TACS_IRQ_EOS 0
`define TACS_RESET_WORD 32'h0000_0000
`endif

// File: hdl/tacs_fifo.v
`timescale 1ns/1ps
`default_nettype none
// ==================================================
// Result FIFO
module tacs_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire in_valid_in,
    output wire in_ready_out,
    input wire [WIDTH-1:0] in_data_in,
    output wire out_valid_out,
    input wire out_ready_in,
    output wire [WIDTH-1:0] out_data_out,
    output reg [AW-1:0] wr_ptr_out,
    output reg [AW-1:0] rd_ptr_out,
    output reg [AW:0] count_out
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    wire push;
    wire pop;
    assign in_ready_out = (count_out != DEPTH[AW:0]);
    assign out_valid_out = (count_out != {(AW+1){1'b0}});
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem[rd_ptr_out];
    // Storage written only on accepted push
    always @(posedge ref_clk_in) begin
        if (push) begin
            mem[wr_ptr_out] <= in_data_in;
        end
    end
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            wr_ptr_out <= {AW{1'b0}};
            rd_ptr_out <= {AW{1'b0}};
            count_out <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_out <= (wr_ptr_out == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                    : wr_ptr_out + 1'b1;
            end
            if (pop) begin
                rd_ptr_out <= (rd_ptr_out == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                    : rd_ptr_out + 1'b1;
            end
            if (push && !pop) begin
                count_out <= count_out + 1'b1;
            end else if (pop && !push) begin
                count_out <= count_out - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: hdl/tacs_top.v
`timescale 1ns/1ps
`default_nettype none
`include "tacs_map.vh"
// ==================================================
// Touch ADC control and status registers
module tacs_top #(
    parameter WIDTH = 16,
    parameter DEPTH = 16,
    parameter AW = 4,
    parameter SETW = 9
) (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [7:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output wire pready_out,
    output wire pslverr_out,
    input wire result_valid_in,
    input wire [WIDTH-1:0] result_data_in,
    output wire result_ready_out,
    output wire rd_valid_out,
    output wire [WIDTH-1:0] rd_data_out,
    input wire rd_ready_in,
    input wire [AW-1:0] watermark_level_in,
    input wire [4:0] irq_mask_in,
    input wire supply_drop_in,
    input wire pen_down_in,
    input wire sequence_end_in,
    input wire idle_enter_in,
    input wire conv_clk_tick_in,
    output reg pen_irq_enable_out,
    output reg [3:0] idle_positive_input_select_out,
    output reg idle_negative_input_select_out,
    output reg [1:0] idle_positive_reference_select_out,
    output reg [11:0] idle_bias_switches_out,
    output reg [1:0] idle_negative_reference_select_out,
    output wire overrun_irq_out,
    output reg [2:0] clear_pulse_out
);
    reg [15:0] bank [0:31];
    reg [15:0] idle_high_word;
    reg [13:0] idle_low_word;
    reg fifo_overrun_flag;
    reg supply_drop_irq;
    reg pen_down_irq;
    reg sequence_end_irq;
    reg [SETW-1:0] settle_cnt;
    reg settling;
    wire [AW-1:0] fifo_write_location;
    wire [AW-1:0] fifo_read_location;
    wire [AW:0] count;
    wire fifo_full_flag;
    wire fifo_empty_flag;
    wire fifo_at_watermark_flag;
    wire wr_en;
    wire rd_en;
    wire fifo_ready;
    wire [4:0] masked_irq_view;
    wire [31:0] fifo_fill_view;
    wire [2:0] clr;
    assign pready_out = 1'b1;
    assign pslverr_out = 1'b0;
    assign wr_en = psel_in && penable_in && pwrite_in;
    assign rd_en = psel_in && penable_in && !pwrite_in;
    // ==================================================
    // Result FIFO instance
    tacs_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH), .AW(AW)) u_fifo (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_in),
        .in_valid_in(result_valid_in),
        .in_ready_out(fifo_ready),
        .in_data_in(result_data_in),
        .out_valid_out(rd_valid_out),
        .out_ready_in(rd_ready_in),
        .out_data_out(rd_data_out),
        .wr_ptr_out(fifo_write_location),
        .rd_ptr_out(fifo_read_location),
        .count_out(count)
    );
    assign result_ready_out = fifo_ready;
    assign fifo_full_flag = (count == DEPTH[AW:0]);
    assign fifo_empty_flag = (count == {(AW+1){1'b0}});
    // watermark; level 0..15 means 1..16 entries, clears below
    assign fifo_at_watermark_flag = (count >= ({1'b0, watermark_level_in} + 1'b1));
    assign fifo_fill_view = {20'h0_0000, fifo_write_location, fifo_read_location,
        fifo_full_flag, fifo_empty_flag, fifo_overrun_flag, fifo_at_watermark_flag};
    assign overrun_irq_out = fifo_overrun_flag;
    assign masked_irq_view = {supply_drop_irq, pen_down_irq, sequence_end_irq,
        fifo_at_watermark_flag, fifo_overrun_flag} & irq_mask_in;
    assign clr = (wr_en && paddr_in == `TACS_CLEAR_ADDR) ? pwdata_in[2:0] : 3'h0;
    // ==================================================
    // Overrun flag; set wins over read clear
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            fifo_overrun_flag <= 1'b0;
        end else if (result_valid_in && fifo_full_flag) begin
            // every dropped arrival flags, even beside a read
            fifo_overrun_flag <= 1'b1;
        end else if (rd_valid_out && rd_ready_in) begin
            fifo_overrun_flag <= 1'b0;
        end
    end
    // ==================================================
    // Latched interrupts; a new event beats its clear
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            supply_drop_irq <= 1'b0;
            pen_down_irq <= 1'b0;
            sequence_end_irq <= 1'b0;
            clear_pulse_out <= 3'h0;
        end else begin
            clear_pulse_out <= clr;
            supply_drop_irq <= supply_drop_in | (supply_drop_irq & ~clr[`TACS_IRQ_BO]);
            pen_down_irq <= (pen_down_in & pen_irq_enable_out)
                | (pen_down_irq & ~clr[`TACS_IRQ_PEN]);
            sequence_end_irq <= sequence_end_in | (sequence_end_irq & ~clr[`TACS_IRQ_EOS]);
        end
    end
    // ==================================================
    // Register writes
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            idle_high_word <= 16'h0000;
            idle_low_word <= 14'h0000;
        end else if (wr_en) begin
            if (paddr_in == `TACS_IDLE_HIGH_ADDR) begin
                idle_high_word <= pwdata_in[15:0];
            end else if (paddr_in == `TACS_IDLE_LOW_ADDR) begin
                idle_low_word <= pwdata_in[13:0];
            end
        end
    end
    // bank of 32 words, even index high word, odd low word
    always @(posedge ref_clk_in) begin
        if (wr_en && paddr_in >= `TACS_BANK_BASE_ADDR && paddr_in < `TACS_IDLE_HIGH_ADDR
            && paddr_in[1:0] == 2'b00) begin
            bank[paddr_in[6:2] - 5'h09] <= pwdata_in[15:0];
        end
    end
    // ==================================================
    // Idle routing outputs
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            idle_positive_input_select_out <= 4'h0;
            idle_negative_input_select_out <= 1'b0;
            idle_positive_reference_select_out <= 2'h0;
            idle_bias_switches_out <= 12'h000;
            idle_negative_reference_select_out <= 2'h0;
        end else begin
            idle_positive_input_select_out <= idle_high_word[`TACS_INP_HI:`TACS_INP_LO];
            idle_negative_input_select_out <= idle_high_word[`TACS_INM];
            idle_positive_reference_select_out <= idle_high_word[`TACS_REF_HI:`TACS_REF_LO];
            // bias switches, all twelve bits from low word 13:2
            idle_bias_switches_out <= idle_low_word[`TACS_BIAS_HI:`TACS_BIAS_LO];
            idle_negative_reference_select_out <= idle_low_word[`TACS_REF_HI:`TACS_REF_LO];
        end
    end
    // ==================================================
    // Idle settle counter in converter clock ticks
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            settle_cnt <= {SETW{1'b0}};
            settling <= 1'b0;
            pen_irq_enable_out <= 1'b0;
        end else if (idle_enter_in) begin
            settle_cnt <= idle_high_word[`TACS_SETTLE_HI:`TACS_SETTLE_LO];
            settling <= 1'b1;
            pen_irq_enable_out <= 1'b0;
        end else if (settling) begin
            if (settle_cnt == {SETW{1'b0}}) begin
                settling <= 1'b0;
                pen_irq_enable_out <= 1'b1;
            end else if (conv_clk_tick_in) begin
                settle_cnt <= settle_cnt - 1'b1;
            end
        end
    end
    // ==================================================
    // Read mux; unmapped reads zero
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            prdata_out <= `TACS_RESET_WORD;
        end else if (psel_in && !penable_in && !pwrite_in) begin
            if (paddr_in == `TACS_FILL_VIEW_ADDR) begin
                prdata_out <= fifo_fill_view;
            end else if (paddr_in == `TACS_IDLE_HIGH_ADDR) begin
                prdata_out <= {16'h0000, idle_high_word};
            end else if (paddr_in == `TACS_IDLE_LOW_ADDR) begin
                prdata_out <= {18'h0_0000, idle_low_word};
            end else if (paddr_in == `TACS_MASKED_ADDR) begin
                prdata_out <= {27'h000_0000, masked_irq_view};
            end else if (paddr_in >= `TACS_BANK_BASE_ADDR && paddr_in < `TACS_IDLE_HIGH_ADDR
                && paddr_in[1:0] == 2'b00) begin
                prdata_out <= {16'h0000, bank[paddr_in[6:2] - 5'h09]
                    & (paddr_in[2] ? 16'hFFFF : `TACS_LOW_MASK)};
            end else begin
                prdata_out <= `TACS_RESET_WORD;
            end
        end
    end
endmodule
`default_nettype wire

// File: sim/tacs_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Port checks for the control and status block
module tacs_chk (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic result_valid_in,
    input wire logic result_ready_out,
    input wire logic rd_valid_out,
    input wire logic rd_ready_in,
    input wire logic [3:0] idle_positive_input_select_out,
    input wire logic idle_negative_input_select_out,
    input wire logic [1:0] idle_positive_reference_select_out,
    input wire logic [11:0] idle_bias_switches_out,
    input wire logic [1:0] idle_negative_reference_select_out,
    input wire logic overrun_irq_out,
    input wire logic [2:0] clear_pulse_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    // Bus phase and FIFO pop decode, shared by all properties
    wire logic acc_wr = psel_in && penable_in && pwrite_in;
    wire logic setup = psel_in && !penable_in;
    wire logic pop = rd_valid_out && rd_ready_in;
    logic [31:0] pw_q;
    logic [31:0] pw_qq;
    // Write data delayed; idle outputs copy a register, so land two edges late
    always_ff @(posedge ref_clk_in) begin
        pw_q <= pwdata_in;
        pw_qq <= pw_q;
    end
    property p_clr_pulse;
        acc_wr && paddr_in == 8'hB0 |=> clear_pulse_out == pw_q[2:0];
    endproperty
    a_clr_pulse: assert property (p_clr_pulse) else $error("clear pulse bits wrong");
    property p_clr_once;
        clear_pulse_out != 3'h0 && !acc_wr |=> clear_pulse_out == 3'h0;
    endproperty
    a_clr_once: assert property (p_clr_once) else $error("clear pulse too long");
    property p_ovr_set;
        result_valid_in && !result_ready_out && !pop |=> overrun_irq_out;
    endproperty
    a_ovr_set: assert property (p_ovr_set) else $error("overrun not raised");
    property p_ovr_clr;
        overrun_irq_out && pop && !result_valid_in |=> !overrun_irq_out;
    endproperty
    a_ovr_clr: assert property (p_ovr_clr) else $error("overrun not cleared");
    // Fill view full, empty and overrun flags must mirror live FIFO ready, valid and overrun
    property p_fs_flags;
        setup && paddr_in == 8'h20 |=> prdata_out[3:1] ==
            {!$past(result_ready_out), !$past(rd_valid_out), $past(overrun_irq_out)};
    endproperty
    a_fs_flags: assert property (p_fs_flags) else $error("fill flags wrong");
    property p_idle_hi;
        acc_wr && paddr_in == 8'hA4 |-> ##2 idle_positive_input_select_out == pw_qq[6:3]
            && idle_negative_input_select_out == pw_qq[2]
            && idle_positive_reference_select_out == pw_qq[1:0];
    endproperty
    a_idle_hi: assert property (p_idle_hi) else $error("idle high fields wrong");
    property p_idle_lo;
        acc_wr && paddr_in == 8'hA8 |-> ##2 idle_bias_switches_out == pw_qq[13:2]
            && idle_negative_reference_select_out == pw_qq[1:0];
    endproperty
    a_idle_lo: assert property (p_idle_lo) else $error("idle low fields wrong");
    property p_idle_rsv;
        setup && (paddr_in == 8'hA4 || paddr_in == 8'hA8) |=> prdata_out[31:16] == 16'h0000;
    endproperty
    a_idle_rsv: assert property (p_idle_rsv) else $error("idle upper bits set");
    property p_bank_lo;
        setup && paddr_in >= 8'h24 && paddr_in <= 8'hA0 && !paddr_in[2]
            |=> prdata_out[15:14] == 2'b00;
    endproperty
    a_bank_lo: assert property (p_bank_lo) else $error("low word top bits set");
    property p_mis_rsv;
        setup && paddr_in == 8'hAC |=> prdata_out[31:5] == 27'h000_0000;
    endproperty
    a_mis_rsv: assert property (p_mis_rsv) else $error("masked view upper bits set");
    c_full: cover property (!result_ready_out);
    c_ovr: cover property ($rose(overrun_irq_out));
    c_clr: cover property (clear_pulse_out == 3'h5);
endmodule
bind tacs_top tacs_chk chk (.ref_clk_in, .rst_n_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .pwdata_in, .prdata_out, .result_valid_in, .result_ready_out, .rd_valid_out,
    .rd_ready_in, .idle_positive_input_select_out, .idle_negative_input_select_out,
    .idle_positive_reference_select_out,
    .idle_bias_switches_out, .idle_negative_reference_select_out, .overrun_irq_out,
    .clear_pulse_out);
`default_nettype wire

// File: sim/tacs_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Converter front end: a burst of numbered results
module tacs_conv_model (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic load_in,
    input wire logic [4:0] count_in,
    output logic valid_out,
    output logic [15:0] data_out,
    output logic busy_out
);
    logic [4:0] left;
    logic [15:0] seq;
    // The converter never waits for room, so a full FIFO must drop
    always_ff @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            left <= 5'h00;
            seq <= 16'h0000;
        end else if (load_in) begin
            left <= count_in;
        end else if (left != 5'h00) begin
            left <= left - 5'h01;
            seq <= seq + 16'h0001;
        end
    end
    // Data is scrambled outside a result so stale values never match
    assign valid_out = left != 5'h00;
    assign data_out = valid_out ? seq : ~seq;
    assign busy_out = valid_out;
endmodule
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Register and result FIFO bench
module tb_top;
    logic clk = 0, rst_n = 0, sel = 0, en = 0, we = 0, ld = 0, rdy = 0;
    logic sd = 0, pd = 0, se = 0, ie = 0, tk = 0;
    logic [1:0] tcnt = 2'd0;
    logic [7:0] a = 8'h00;
    logic [31:0] wd = 32'h0000_0000;
    logic [4:0] mask = 5'h1F, cnt = 5'h00;
    logic [31:0] prd;
    logic [15:0] rv_d, rd_d;
    logic v, rs_rdy, rd_v, pen_en, busy, bus_rdy, bus_err;
    int miscompares = 0, total_checks = 0;
    tacs_top dut (.ref_clk_in(clk), .rst_n_in(rst_n), .psel_in(sel), .penable_in(en),
        .pwrite_in(we), .paddr_in(a), .pwdata_in(wd), .prdata_out(prd), .pready_out(bus_rdy),
        .pslverr_out(bus_err), .result_valid_in(v), .result_data_in(rv_d),
        .result_ready_out(rs_rdy),
        .rd_valid_out(rd_v), .rd_data_out(rd_d), .rd_ready_in(rdy), .watermark_level_in(4'h3),
        .irq_mask_in(mask), .supply_drop_in(sd), .pen_down_in(pd), .sequence_end_in(se),
        .idle_enter_in(ie), .conv_clk_tick_in(tk), .pen_irq_enable_out(pen_en),
        .idle_positive_input_select_out(), .idle_negative_input_select_out(),
        .idle_positive_reference_select_out(), .idle_bias_switches_out(),
        .idle_negative_reference_select_out(), .overrun_irq_out(), .clear_pulse_out());
    tacs_conv_model cm (.ref_clk_in(clk), .rst_n_in(rst_n), .load_in(ld), .count_in(cnt),
        .valid_out(v), .data_out(rv_d), .busy_out(busy));
    initial begin
        forever #5 clk = ~clk;
    end
    // Converter clock tick every fourth system clock
    always @(posedge clk) begin
        tcnt <= tcnt + 2'd1;
        tk <= &tcnt;
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic finish_test;
        if (miscompares == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Setup edge then access edge; ready is tied high
    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge clk);
        {sel, we, a, wd} <= {2'b11, ad, d};
        @(posedge clk);
        en <= 1;
        @(posedge clk);
        {sel, en} <= 2'b00;
    endtask
    task automatic rc(input string n, input logic [7:0] ad, input logic [31:0] e);
        @(posedge clk);
        {sel, we, a} <= {2'b10, ad};
        @(posedge clk);
        en <= 1;
        @(posedge clk);
        chk(n, e, prd);
        chk("resp", 32'h0000_0001, {30'h0000_0000, bus_err, bus_rdy});
        {sel, en} <= 2'b00;
    endtask
    task automatic pop(input logic [15:0] e);
        @(negedge clk);
        chk("head", {15'h0000, 1'b1, e}, {15'h0000, rd_v, rd_d});
        @(posedge clk);
        rdy <= 1;
        @(posedge clk);
        rdy <= 0;
    endtask
    // Burst of results; a stuck converter ends the run
    task automatic send(input logic [4:0] n);
        int i;
        @(posedge clk);
        {ld, cnt} <= {1'b1, n};
        @(posedge clk);
        ld <= 0;
        repeat (2) @(negedge clk);
        for (i = 0; i < 40 && busy; i++) @(negedge clk);
        if (busy) begin
            miscompares++;
            finish_test;
        end
    endtask
    initial begin
        int i;
        logic [15:0] p;
        repeat (10) @(posedge clk);
        rst_n <= 1;
        rc("fill", 8'h20, 32'h0000_0004);
        rc("mis", 8'hAC, 32'h0000_0000);
        for (i = 0; i < 32; i++) wr(8'h24 + 8'(i * 4), {16'hFFFF, 16'hC0A5 ^ 16'(i)});
        for (i = 0; i < 32; i++) begin
            p = 16'hC0A5 ^ 16'(i);
            rc("bank", 8'h24 + 8'(i * 4), {16'h0000, i[0] ? p & 16'h3FFF : p});
        end
        wr(8'hA4, 32'hFFFF_01D6);
        rc("idle_hi", 8'hA4, 32'h0000_01D6);
        wr(8'hA8, 32'hFFFF_C5FF);
        rc("idle_lo", 8'hA8, 32'h0000_05FF);
        wr(8'hFC, 32'hFFFF_FFFF);
        rc("unmapped", 8'hFC, 32'h0000_0000);
        @(posedge clk);
        {ie, pd} <= 2'b11;
        @(posedge clk);
        ie <= 0;
        repeat (4) @(negedge clk);
        chk("pen_en", 32'h0000_0000, {31'h0000_0000, pen_en});
        repeat (20) @(negedge clk);
        chk("pen_en", 32'h0000_0001, {31'h0000_0000, pen_en});
        rc("mis", 8'hAC, 32'h0000_0008);
        pd <= 0;
        wr(8'hB0, 32'h0000_0002);
        rc("mis", 8'hAC, 32'h0000_0000);
        send(5'd3);
        rc("fill", 8'h20, 32'h0000_0300);
        send(5'd1);
        rc("fill", 8'h20, 32'h0000_0401);
        send(5'd13);
        rc("fill", 8'h20, 32'h0000_000B);
        @(posedge clk);
        {sd, se} <= 2'b11;
        @(posedge clk);
        {sd, se} <= 2'b00;
        rc("mis", 8'hAC, 32'h0000_0017);
        wr(8'hB0, 32'h0000_0005);
        rc("mis", 8'hAC, 32'h0000_0003);
        mask <= 5'h00;
        rc("mis", 8'hAC, 32'h0000_0000);
        mask <= 5'h1F;
        pop(16'h0000);
        rc("fill", 8'h20, 32'h0000_0011);
        for (i = 1; i < 13; i++) pop(16'(i));
        rc("fill", 8'h20, 32'h0000_00D0);
        for (i = 13; i < 16; i++) pop(16'(i));
        rc("fill", 8'h20, 32'h0000_0004);
        finish_test;
    end
endmodule
`default_nettype wire
